// ---- rtl/mcq_map.svh ----
// offsets, field codes, reset values and timing counts for the motion capture block
`ifndef MCQ_MAP_SVH
`define MCQ_MAP_SVH
`define MCQ_FILTER_SAMPLES 4
`define MCQ_TIMER_MAX 16'hFFFF
`define MCQ_TIMER_ZERO 16'h0000
`define MCQ_FREE_LIMIT 16'hFFFF
`define MCQ_EDGE_RISE 2'h0
`define MCQ_EDGE_FALL 2'h1
`define MCQ_EDGE_BOTH 2'h2
`define MCQ_SRC_NONE 2'h3
`define MCQ_SEL_LATCH 2'h0
`define MCQ_SEL_COUNT 2'h1
`define MCQ_SEL_LIMIT 2'h2
`endif

// ---- rtl/mcq_pkg.sv ----
// types shared by the motion capture block
package mcq_pkg;
   typedef enum logic [1:0] {
      MCQ_X4_FREE,
      MCQ_X2_FREE,
      MCQ_X4_CMP,
      MCQ_X2_CMP
   } mcq_qmode_type;
   typedef struct packed {
      logic [2:0] noise_filter_on;
      logic [5:0] trigger_edge_select;
      logic [2:0] capture_channel_on;
      logic clear_after_capture;
      logic reload_value_on;
      logic compare_not_reload;
      logic [1:0] capture_reload_source;
      logic quadrature_on;
      logic index_input_off;
      mcq_qmode_type qmode;
   } mcq_cfg_type;
   typedef struct packed {
      logic [1:0] sel;
      logic [15:0] data;
   } mcq_wr_type;
endpackage

// ---- rtl/mcq_filter.sv ----
// one input channel: synchroniser, optional run-of-four filter, edge detect
`timescale 1ns/1ps
`include "mcq_map.svh"
module mcq_filter #(
   parameter int RUN = `MCQ_FILTER_SAMPLES
) (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, low
   input wire logic pin_in, // raw pin
   input wire logic filt_on_in, // filter enable
   output logic level_out, // filtered level
   output logic rise_out, // rising edge pulse
   output logic fall_out // falling edge pulse
);
   initial
   begin
      if (RUN < 2 || RUN > 15) $error("mcq_filter: RUN out of range");
   end
   logic meta_q, sync_q, lvl_q, prev_q;
   logic meta_d, sync_d, lvl_d, prev_d;
   logic [3:0] run_q, run_d; // count of equal new samples
   // next state: with the filter on, level moves only after RUN equal differing samples; off, it follows sync
   always_comb
   begin
      meta_d = pin_in;
      sync_d = meta_q;
      run_d = run_q;
      lvl_d = lvl_q;
      prev_d = lvl_q;
      if (!filt_on_in)
      begin
         lvl_d = sync_q;
         run_d = 4'h0;
      end
      else if (sync_q == lvl_q)
         run_d = 4'h0; // glitch ends the run
      else if (run_q == 4'(RUN - 1))
      begin
         lvl_d = sync_q;
         run_d = 4'h0;
      end
      else
         run_d = run_q + 4'h1;
   end
   // registers only
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         lvl_q <= 1'b0;
         prev_q <= 1'b0;
         run_q <= 4'h0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         lvl_q <= lvl_d;
         prev_q <= prev_d;
         run_q <= run_d;
      end
   end
   assign level_out = lvl_q;
   assign rise_out = lvl_q & ~prev_q;
   assign fall_out = ~lvl_q & prev_q;
endmodule

// ---- rtl/mcq_regs.sv ----
// small three-word store for capture values, registered read port
`timescale 1ns/1ps
module mcq_regs #(
   parameter int WIDTH = 16
) (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, low
   input wire logic [2:0] we_in, // per word write
   input wire logic [WIDTH-1:0] wdata_in, // shared write data
   input wire logic [1:0] raddr_in, // read index
   output logic [WIDTH-1:0] rdata_out // registered read data
);
   initial
   begin
      if (WIDTH < 1) $error("mcq_regs: bad WIDTH");
   end
   logic [WIDTH-1:0] mem_q [3];
   logic [WIDTH-1:0] mem_d [3];
   logic [WIDTH-1:0] rd_q, rd_d;
   // write and read selection
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         mem_d[i] = we_in[i] ? wdata_in : mem_q[i];
      rd_d = (raddr_in < 2'h3) ? mem_q[raddr_in] : '0;
   end
   // registers only
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < 3; i++)
            mem_q[i] <= '0;
         rd_q <= '0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
            mem_q[i] <= mem_d[i];
         rd_q <= rd_d;
      end
   end
   assign rdata_out = rd_q;
endmodule

// ---- rtl/mcq_top.sv ----
// motion capture block: three capture channels, aux timer, quadrature counter
`timescale 1ns/1ps
`include "mcq_map.svh"
module mcq_top (
   input wire logic CLK_IN, // 20 MHz system clock
   input wire logic RST_N_IN, // sync reset, low
   input wire logic [2:0] CAP_PIN_IN, // capture pins 0..2 (async)
   input wire mcq_pkg::mcq_cfg_type CFG_IN, // control bits
   input wire logic [2:0] FLAG_CLR_IN, // clear pulses, capture flags
   input wire logic TFLAG_CLR_IN, // clear pulse, timer flag
   input wire logic CAPTURE_IRQ_ON_IN, // capture irq enable
   input wire logic AUX_TIMER_IRQ_ON_IN, // timer irq enable
   input wire logic TIMER_WR_IN, // write timer count
   input wire logic RELOAD_WR_IN, // write reload/compare value
   input wire logic WORD_WR_IN, // write shared word
   input wire mcq_pkg::mcq_wr_type WR_IN, // word select and data
   input wire logic [15:0] WDATA_IN, // timer/reload write data
   input wire logic [1:0] RD_SEL_IN, // shared word read select
   output logic [15:0] RD_DATA_OUT, // shared word read data
   output logic [15:0] AUX_TIMER_OUT, // timer count
   output logic [15:0] RELOAD_OUT, // reload/compare value
   output logic [2:0] CAPTURE_EVENT_FLAG_OUT, // capture flags
   output logic AUX_TIMER_EVENT_FLAG_OUT, // timer flag
   output logic HEADING_OUT, // direction, 1 up
   output logic CAPTURE_IRQ_OUT, // capture irq request
   output logic AUX_TIMER_IRQ_OUT // timer irq request
);
   // edge selection per channel
   function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
      case (sel)
         `MCQ_EDGE_RISE: edge_hit = r;
         `MCQ_EDGE_FALL: edge_hit = f;
         `MCQ_EDGE_BOTH: edge_hit = r | f;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   mcq_pkg::mcq_cfg_type cfg;
   assign cfg = CFG_IN;
   logic [2:0] lvl, rise, fall, trig;
   logic quad; // quadrature mode owns pins 0 and 1
   assign quad = cfg.quadrature_on;

   // per-channel filter and edge detect, pins synchronised inside
   for (genvar g = 0; g < 3; g++)
   begin : g_ch
      mcq_filter #(
         .RUN(`MCQ_FILTER_SAMPLES)
      ) u_filt (
         .clk_in(CLK_IN),
         .rst_n_in(RST_N_IN),
         .pin_in(CAP_PIN_IN[g]),
         .filt_on_in(cfg.noise_filter_on[g]),
         .level_out(lvl[g]),
         .rise_out(rise[g]),
         .fall_out(fall[g])
      );
   end

   // trigger qualification; pins 0/1 belong to the encoder in quadrature mode
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         trig[i] = cfg.capture_channel_on[i]
                   & edge_hit(cfg.trigger_edge_select[2*i +: 2], rise[i], fall[i]);
      trig[0] = trig[0] & ~quad;
      trig[1] = trig[1] & ~quad;
      trig[2] = trig[2] & ~(quad & cfg.index_input_off);
   end

   // aux timer state
   logic [15:0] tmr_q, tmr_d, rld_q, rld_d;
   logic tf_q, tf_d;
   logic cap_any, src_hit;
   always_comb
   begin
      cap_any = |trig[2:0] & ~quad | (trig[2] & quad);
      src_hit = (cfg.capture_reload_source != `MCQ_SRC_NONE)
                & trig[cfg.capture_reload_source];
   end

   // timer next value; clear after capture wins over everything
   always_comb
   begin
      tmr_d = tmr_q + 16'h0001;
      rld_d = rld_q;
      tf_d = tf_q & ~TFLAG_CLR_IN;
      if (RELOAD_WR_IN)
         rld_d = WDATA_IN;
      if (cfg.clear_after_capture && cap_any)
         tmr_d = `MCQ_TIMER_ZERO;
      else if (src_hit)
         tmr_d = cfg.reload_value_on ? rld_q : `MCQ_TIMER_ZERO;
      else if (TIMER_WR_IN)
         tmr_d = WDATA_IN;
      else if (cfg.compare_not_reload && tmr_q == rld_q)
      begin
         tmr_d = `MCQ_TIMER_ZERO;
         tf_d = 1'b1;
      end
      else if (!cfg.compare_not_reload && tmr_q == `MCQ_TIMER_MAX)
      begin
         tf_d = 1'b1;
         if (!cfg.clear_after_capture && cfg.reload_value_on)
            tmr_d = rld_q;
         else
            tmr_d = `MCQ_TIMER_ZERO;
      end
   end

   // timer registers
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         tmr_q <= `MCQ_TIMER_ZERO;
         rld_q <= `MCQ_TIMER_ZERO;
         tf_q <= 1'b0;
      end
      else
      begin
         tmr_q <= tmr_d;
         rld_q <= rld_d;
         tf_q <= tf_d;
      end
   end

   // quadrature decode from filtered phases
   logic pa, pb, pa_r, pa_f, pb_r, pb_f;
   assign pa = lvl[0];
   assign pb = lvl[1];
   assign pa_r = rise[0];
   assign pa_f = fall[0];
   assign pb_r = rise[1];
   assign pb_f = fall[1];
   logic x2, cmp_mode, step, up;
   logic [15:0] cnt_q, cnt_d, lim, latch_q, latch_d;
   logic [15:0] lim_word; // limit word, own register written with slot 2 on quadrature limit writes, reset to all ones
   logic dir_q, dir_d;
   logic [2:0] flg_q, flg_d;
   always_comb
   begin
      x2 = (cfg.qmode == mcq_pkg::MCQ_X2_FREE) | (cfg.qmode == mcq_pkg::MCQ_X2_CMP);
      cmp_mode = (cfg.qmode == mcq_pkg::MCQ_X4_CMP) | (cfg.qmode == mcq_pkg::MCQ_X2_CMP);
      lim = cmp_mode ? lim_word : `MCQ_FREE_LIMIT;
      // A leads B: A rises with B low, A falls with B high, etc.
      up = (pa_r & ~pb) | (pa_f & pb) | (pb_r & pa) | (pb_f & ~pa);
      step = quad & (x2 ? (pa_r | pa_f) : (pa_r | pa_f | pb_r | pb_f));
   end

   // counter, direction and flag next values
   always_comb
   begin
      cnt_d = cnt_q; // held when mode changes or quadrature off
      dir_d = dir_q;
      latch_d = cnt_q; // read buffer follows the counter
      flg_d = flg_q & ~FLAG_CLR_IN;
      if (WORD_WR_IN && quad && WR_IN.sel == `MCQ_SEL_COUNT)
         cnt_d = WR_IN.data;
      if (step)
      begin
         dir_d = up;
         if (up != dir_q)
            flg_d[1] = 1'b1;
         if (up)
         begin
            if (cnt_q >= lim)
            begin
               cnt_d = `MCQ_TIMER_ZERO;
               flg_d[0] = 1'b1;
            end
            else
               cnt_d = cnt_q + 16'h0001;
         end
         else if (cnt_q == `MCQ_TIMER_ZERO)
         begin
            cnt_d = lim;
            flg_d[0] = 1'b1;
         end
         else
            cnt_d = cnt_q - 16'h0001;
      end
      if (!quad)
         flg_d = flg_d | trig;
      else if (trig[2])
         flg_d[2] = 1'b1;
   end

   // quadrature and flag registers; set wins over clear above
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         cnt_q <= `MCQ_TIMER_ZERO;
         latch_q <= `MCQ_TIMER_ZERO;
         dir_q <= 1'b1;
         flg_q <= 3'h0;
      end
      else
      begin
         cnt_q <= cnt_d;
         latch_q <= latch_d;
         dir_q <= dir_d;
         flg_q <= flg_d;
      end
   end

   // capture store writes: capture value in capture mode, limit in quadrature
   logic [2:0] st_we;
   logic [15:0] st_wd;
   logic [15:0] st_rd;
   always_comb
   begin
      st_we = 3'h0;
      st_wd = tmr_q;
      if (!quad)
         st_we = trig;
      else if (WORD_WR_IN && WR_IN.sel == `MCQ_SEL_LIMIT)
      begin
         st_we = 3'h4; // limit word
         st_wd = WR_IN.data;
      end
      else if (trig[2])
         st_we = 3'h4 & {3{1'b0}}; // slot 2 holds the limit in quadrature
      if (!quad && WORD_WR_IN && WR_IN.sel < 2'h3)
      begin
         st_we = st_we | (3'h1 << WR_IN.sel);
         st_wd = (|trig) ? tmr_q : WR_IN.data; // capture wins the shared port
      end
   end

   mcq_regs #(
      .WIDTH(16)
   ) u_store (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .we_in(st_we),
      .wdata_in(st_wd),
      .raddr_in(RD_SEL_IN),
      .rdata_out(st_rd)
   );

   // limit mirror so the counter can compare without a read port
   logic [15:0] lim_q, lim_d;
   always_comb
   begin
      lim_d = lim_q;
      if (quad && WORD_WR_IN && WR_IN.sel == `MCQ_SEL_LIMIT)
         lim_d = WR_IN.data;
   end
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         lim_q <= `MCQ_FREE_LIMIT;
      else
         lim_q <= lim_d;
   end
   assign lim_word = lim_q;

   // read mux: quadrature mode remaps the three words
   logic [15:0] rd_q, rd_d;
   always_comb
   begin
      rd_d = st_rd;
      if (quad)
         case (RD_SEL_IN)
            `MCQ_SEL_LATCH: rd_d = latch_q;
            `MCQ_SEL_COUNT: rd_d = cnt_q;
            `MCQ_SEL_LIMIT: rd_d = lim_q;
            default: rd_d = 16'h0000;
         endcase
   end
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_N_IN)
         rd_q <= 16'h0000;
      else
         rd_q <= rd_d;
   end

   assign RD_DATA_OUT = quad ? rd_q : st_rd;
   assign AUX_TIMER_OUT = tmr_q;
   assign RELOAD_OUT = rld_q;
   assign CAPTURE_EVENT_FLAG_OUT = flg_q;
   assign AUX_TIMER_EVENT_FLAG_OUT = tf_q;
   assign HEADING_OUT = dir_q;
   assign CAPTURE_IRQ_OUT = CAPTURE_IRQ_ON_IN & (|flg_q);
   assign AUX_TIMER_IRQ_OUT = AUX_TIMER_IRQ_ON_IN & tf_q;
endmodule

// ---- verif/mcq_src.sv ----
// partner: square-wave and quadrature source on the capture pins
`timescale 1ns/1ps
module mcq_src (
   input wire logic clk_in, // bench clock
   input wire logic go_in, // one edge request
   input wire logic quad_in, // 1 quadrature step
   input wire logic up_in, // step direction
   input wire logic [1:0] chan_in, // pin to toggle, 3 both 0,1
   input wire logic [3:0] hold_in, // cycles to hold
   output logic [2:0] pin_out, // pins
   output logic busy_out // still holding
);
   logic [1:0] ph_q; // quadrature phase
   logic [1:0] nxt; // next phase
   logic [3:0] cnt_q; // hold count
   initial
   begin
      pin_out = 3'h0;
      ph_q = 2'h0;
      cnt_q = 4'h0;
   end
   // one edge per request, then hold it so pulses and gaps stay wide
   always @(posedge clk_in)
   begin
      if (go_in && quad_in)
      begin
         nxt = up_in ? ph_q + 2'h1 : ph_q - 2'h1;
         ph_q <= nxt;
         pin_out[1:0] <= {nxt[1], nxt[1] ^ nxt[0]};
      end
      else if (go_in)
         pin_out <= pin_out ^ (chan_in == 2'h3 ? 3'h3 : 3'(1 << chan_in));
      cnt_q <= go_in ? hold_in : (cnt_q == 4'h0 ? 4'h0 : cnt_q - 4'h1);
   end
   assign busy_out = cnt_q != 4'h0;
endmodule

// ---- verif/mcq_sva.sv ----
// checker: timing relations at the motion capture block ports
`timescale 1ns/1ps
module mcq_sva (
   input wire logic CLK_IN, // clock
   input wire logic RST_N_IN, // reset, low
   input wire mcq_pkg::mcq_cfg_type CFG_IN, // control
   input wire logic [2:0] FLAG_CLR_IN, // flag clears
   input wire logic CAPTURE_IRQ_ON_IN, // capture irq on
   input wire logic AUX_TIMER_IRQ_ON_IN, // timer irq on
   input wire logic TIMER_WR_IN, // timer write
   input wire logic RELOAD_WR_IN, // reload write
   input wire logic [15:0] WDATA_IN, // write data
   input wire logic [15:0] AUX_TIMER_OUT, // timer
   input wire logic [15:0] RELOAD_OUT, // reload
   input wire logic [2:0] CAPTURE_EVENT_FLAG_OUT, // flags
   input wire logic AUX_TIMER_EVENT_FLAG_OUT, // timer flag
   input wire logic HEADING_OUT, // direction
   input wire logic CAPTURE_IRQ_OUT, // capture irq
   input wire logic AUX_TIMER_IRQ_OUT // timer irq
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   a_flag_sticky: assert property (!(|($past(CAPTURE_EVENT_FLAG_OUT) &
      ~CAPTURE_EVENT_FLAG_OUT & ~$past(FLAG_CLR_IN)))) else $error("flag dropped");
   a_cap_irq_or: assert property (CAPTURE_IRQ_OUT ==
      (CAPTURE_IRQ_ON_IN && |CAPTURE_EVENT_FLAG_OUT)) else $error("capture irq");
   a_tmr_irq_and: assert property (AUX_TIMER_IRQ_OUT ==
      (AUX_TIMER_IRQ_ON_IN && AUX_TIMER_EVENT_FLAG_OUT)) else $error("timer irq");
   a_reload_write: assert property (RELOAD_WR_IN |=>
      RELOAD_OUT == $past(WDATA_IN)) else $error("reload write");
   a_timer_write: assert property (TIMER_WR_IN && !CFG_IN.clear_after_capture &&
      CFG_IN.capture_reload_source == 2'h3 && !CFG_IN.compare_not_reload &&
      AUX_TIMER_OUT != 16'hFFFF |=> AUX_TIMER_OUT == $past(WDATA_IN)) else $error("timer write");
   a_wrap_load: assert property (!CFG_IN.compare_not_reload && AUX_TIMER_OUT == 16'hFFFF
      && !TIMER_WR_IN |=> AUX_TIMER_EVENT_FLAG_OUT && AUX_TIMER_OUT ==
      (($past(CFG_IN.reload_value_on) && !$past(CFG_IN.clear_after_capture)) ?
      $past(RELOAD_OUT) : 16'h0000)) else $error("overflow load");
   a_cmp_restart: assert property (CFG_IN.compare_not_reload && !TIMER_WR_IN
      && !RELOAD_WR_IN && AUX_TIMER_OUT == RELOAD_OUT |=> AUX_TIMER_EVENT_FLAG_OUT
      && AUX_TIMER_OUT == 16'h0000) else $error("compare restart");
   a_clear_cap: assert property (CFG_IN.clear_after_capture &&
      $rose(CAPTURE_EVENT_FLAG_OUT[0]) |-> ##[0:1] AUX_TIMER_OUT == 16'h0000)
      else $error("clear after capture");
   // the flag loads from the trigger seen one cycle earlier, so look back one cycle
   a_index_gate: assert property ($rose(CAPTURE_EVENT_FLAG_OUT[2]) |->
      $past(CFG_IN.capture_channel_on[2]) && !($past(CFG_IN.quadrature_on) &&
      $past(CFG_IN.index_input_off))) else $error("pin 2 gate");
   a_reset_vals: assert property ($rose(RST_N_IN) |->
      CAPTURE_EVENT_FLAG_OUT == 3'h0 && HEADING_OUT) else $error("reset values");
   c_cap2: cover property ($rose(CAPTURE_EVENT_FLAG_OUT[2]));
   c_tflag: cover property ($rose(AUX_TIMER_EVENT_FLAG_OUT));
   c_heading: cover property ($fell(HEADING_OUT));
endmodule
bind mcq_top mcq_sva u_mcq_sva (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CFG_IN(CFG_IN),
   .FLAG_CLR_IN(FLAG_CLR_IN), .CAPTURE_IRQ_ON_IN(CAPTURE_IRQ_ON_IN),
   .AUX_TIMER_IRQ_ON_IN(AUX_TIMER_IRQ_ON_IN), .TIMER_WR_IN(TIMER_WR_IN),
   .RELOAD_WR_IN(RELOAD_WR_IN), .WDATA_IN(WDATA_IN), .AUX_TIMER_OUT(AUX_TIMER_OUT),
   .RELOAD_OUT(RELOAD_OUT), .CAPTURE_EVENT_FLAG_OUT(CAPTURE_EVENT_FLAG_OUT),
   .AUX_TIMER_EVENT_FLAG_OUT(AUX_TIMER_EVENT_FLAG_OUT), .HEADING_OUT(HEADING_OUT),
   .CAPTURE_IRQ_OUT(CAPTURE_IRQ_OUT), .AUX_TIMER_IRQ_OUT(AUX_TIMER_IRQ_OUT));

// ---- verif/tb.sv ----
// bench: partner stimulus, flag scoreboard, verdict
`timescale 1ns/1ps
module tb;
   logic clk; // 20 MHz
   logic rst_n; // sync reset
   mcq_pkg::mcq_cfg_type cfg; // control bits
   mcq_pkg::mcq_wr_type wr; // word write
   logic [2:0] fclr, flags, prev, pins; // clears, flags, last flags, pins
   logic [15:0] wdata, rdata, tmr, rld, a, b; // data, reload and scratch
   logic [1:0] irq_on, rsel, ch; // enables, read select, pin
   logic tclr, twr, rwr, wwr, tflag, heading, go, quad, up, busy; // strobes, status
   logic cirq, tirq; // interrupt requests
   logic [3:0] hld; // partner hold
   logic [2:0] exp_q[$]; // expected flag rises
   int n_errors = 0; // mismatches
   int n_compared = 0; // comparisons
   mcq_top u_mcq_top (.CLK_IN(clk), .RST_N_IN(rst_n), .CAP_PIN_IN(pins), .CFG_IN(cfg),
      .FLAG_CLR_IN(fclr), .TFLAG_CLR_IN(tclr), .CAPTURE_IRQ_ON_IN(irq_on[0]),
      .AUX_TIMER_IRQ_ON_IN(irq_on[1]), .TIMER_WR_IN(twr), .RELOAD_WR_IN(rwr),
      .WORD_WR_IN(wwr), .WR_IN(wr), .WDATA_IN(wdata), .RD_SEL_IN(rsel), .RD_DATA_OUT(rdata),
      .AUX_TIMER_OUT(tmr), .RELOAD_OUT(rld), .CAPTURE_EVENT_FLAG_OUT(flags),
      .AUX_TIMER_EVENT_FLAG_OUT(tflag), .HEADING_OUT(heading), .CAPTURE_IRQ_OUT(cirq),
      .AUX_TIMER_IRQ_OUT(tirq));
   mcq_src u_mcq_src (.clk_in(clk), .go_in(go), .quad_in(quad), .up_in(up), .chan_in(ch),
      .hold_in(hld), .pin_out(pins), .busy_out(busy));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one partner edge; hold 0 picks a random safe width
   task automatic step(input int q, input int u, input int c, input int h);
      go <= 1'b1;
      quad <= 1'(q);
      up <= 1'(u);
      ch <= 2'(c);
      hld <= h ? 4'(h) : 4'(6 + $urandom % 8);
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (busy);
   endtask
   // clear pulses for every flag
   task automatic clr();
      fclr <= 3'h7;
      tclr <= 1'b1;
      @(posedge clk);
      fclr <= 3'h0;
      tclr <= 1'b0;
      @(posedge clk);
   endtask
   // registered read: sample once the select has settled
   task automatic rd(input logic [1:0] s, output logic [15:0] v);
      rsel <= s;
      repeat (3) @(posedge clk);
      v = rdata;
   endtask
   // write: 0 timer, 1 reload, 2 shared word (sel s)
   task automatic wt(input int k, input logic [1:0] s, input logic [15:0] d);
      wdata <= d;
      wr <= '{s, d};
      twr <= k == 0;
      rwr <= k == 1;
      wwr <= k == 2;
      @(posedge clk);
      {twr, rwr, wwr} <= 3'h0;
      @(posedge clk);
   endtask
   // watcher: each new flag takes the oldest note; enables toggle at random
   always @(posedge clk)
   begin
      prev <= flags;
      irq_on <= 2'($urandom);
      if (rst_n)
      begin
         chk("capture irq", 16'(cirq), 16'(irq_on[0] & (|flags)));
         chk("timer irq", 16'(tirq), 16'(irq_on[1] & tflag));
      end
      if (rst_n && (flags & ~prev) != 3'h0)
         chk("flag", 16'(flags & ~prev), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hXXXX);
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial
   begin
      void'($urandom(32'h45fed40a));
      {rst_n, fclr, tclr, twr, rwr, wwr, go, quad, up, ch, hld, rsel} = '0;
      {wr, wdata} = '0;
      cfg = '0;
      cfg.capture_reload_source = 2'h3;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // every edge mode on every pin, rise then fall
      cfg.capture_channel_on <= 3'h7;
      for (int m = 0; m < 3; m++)
      begin
         for (int c = 0; c < 3; c++)
         begin
            cfg.trigger_edge_select[2*c+:2] <= 2'(m);
            if (m != 1)
               exp_q.push_back(3'(1 << c));
            step(0, 0, c, 0);
            clr();
            if (m != 0)
               exp_q.push_back(3'(1 << c));
            step(0, 0, c, 0);
            clr();
         end
      end
      // filtered pin 1: short pulse dropped, then three samples behind pin 0
      cfg.trigger_edge_select <= 6'h00;
      cfg.noise_filter_on <= 3'h2;
      step(0, 0, 1, 1);
      step(0, 0, 1, 1);
      exp_q.push_back(3'h1);
      exp_q.push_back(3'h2);
      step(0, 0, 3, 12);
      rd(2'h0, a);
      rd(2'h1, b);
      // four equal samples: three beyond the single one the unfiltered path takes
      chk("capture gap", b - a, 16'h0003);
      step(0, 0, 3, 0);
      // pin 2 gated by index-off in quadrature mode
      cfg.quadrature_on <= 1'b1;
      cfg.index_input_off <= 1'b1;
      step(0, 0, 2, 0);
      step(0, 0, 2, 0);
      cfg.index_input_off <= 1'b0;
      exp_q.push_back(3'h4);
      step(0, 0, 2, 0);
      step(0, 0, 2, 0);
      clr();
      // x4 up, reverse, x2, then compare wrap
      cfg.qmode <= mcq_pkg::MCQ_X4_FREE;
      a = 16'h0100 + 16'($urandom % 256);
      wt(2, 2'h1, a);
      repeat (3) step(1, 1, 0, 0);
      rd(2'h0, b);
      chk("latch", b, a + 16'h0003);
      chk("heading up", 16'(heading), 16'h0001);
      exp_q.push_back(3'h2);
      repeat (2) step(1, 0, 0, 0);
      chk("heading down", 16'(heading), 16'h0000);
      cfg.qmode <= mcq_pkg::MCQ_X2_FREE;
      rd(2'h1, b);
      chk("count kept", b, a + 16'h0001);
      repeat (2) step(1, 0, 0, 0);
      rd(2'h1, b);
      chk("count x2", b, a);
      clr();
      cfg.qmode <= mcq_pkg::MCQ_X4_CMP;
      wt(2, 2'h2, 16'h0003);
      wt(2, 2'h1, 16'h0002);
      exp_q.push_back(3'h2);
      step(1, 1, 0, 0);
      exp_q.push_back(3'h1);
      step(1, 1, 0, 0);
      rd(2'h1, b);
      chk("wrap", b, 16'h0000);
      clr();
      // x2 compare: phase A falls from zero, reverses and wraps down to the limit
      cfg.qmode <= mcq_pkg::MCQ_X2_CMP;
      exp_q.push_back(3'h3);
      step(1, 0, 0, 0);
      rd(2'h1, b);
      chk("x2 wrap down", b, 16'h0003);
      step(1, 1, 0, 0);
      clr();
      cfg.quadrature_on <= 1'b0;
      // overflow with reload, then with zero, then compare
      cfg.reload_value_on <= 1'b1;
      wt(1, 2'h0, 16'($urandom));
      wt(0, 2'h0, 16'hFFF0);
      repeat (24) @(posedge clk);
      chk("reload flag", 16'(tflag), 16'h0001);
      clr();
      cfg.reload_value_on <= 1'b0;
      wt(0, 2'h0, 16'hFFF0);
      repeat (24) @(posedge clk);
      chk("zero flag", 16'(tflag), 16'h0001);
      cfg.compare_not_reload <= 1'b1;
      wt(1, 2'h0, 16'h0040);
      wt(0, 2'h0, 16'h0000);
      clr();
      repeat (70) @(posedge clk);
      chk("compare flag", 16'(tflag), 16'h0001);
      cfg.compare_not_reload <= 1'b0;
      // clear after capture on pin 0, now high: fall first
      cfg.clear_after_capture <= 1'b1;
      step(0, 0, 0, 0);
      exp_q.push_back(3'h1);
      step(0, 0, 0, 0);
      cfg.clear_after_capture <= 1'b0;
      // pin 2 as reload source
      cfg.reload_value_on <= 1'b1;
      cfg.capture_reload_source <= 2'h2;
      wt(1, 2'h0, 16'h8000);
      chk("reload value", rld, 16'h8000);
      exp_q.push_back(3'h4);
      step(0, 0, 2, 6);
      chk("source reload", 16'(tmr - 16'h8000 < 16'h0020), 16'h0001);
      chk("pending", 16'(exp_q.size()), 16'h0000);
      final_report();
   end
endmodule
